/* design/ccs_clock_stop.sv */
`timescale 1ns/1ps
module ccs_clock_stop #(
   parameter int PD_SETTLE_CYCLES = ccs_pkg::PD_SETTLE_CYC,
   parameter logic [3:0] REVISION_ID = 4'h5, // Arbitrary value
   parameter logic [3:0] VENDOR_ID = 4'h3 // Arbitrary value
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // Raw clocks from the synthesiser
   input wire logic CPU_CLK_RAW,
   input wire logic MID_CLK_RAW,
   input wire logic PCI_CLK_RAW,
   input wire logic REF_CLK_RAW,
   input wire logic USB_CLK_RAW,
   input wire logic VIDEO_HUB_CLOCK_RAW,
   // Power management pins
   input wire logic CPU_HALT_N,
   input wire logic PCI_HALT_N,
   input wire logic POWER_DOWN_N,
   // Serial control port
   input wire logic SCLK_IN,
   input wire logic SDATA_IN,
   output logic SDATA_OUT,
   output logic SDATA_OE,
   // CPU pairs
   output logic [ccs_pkg::NUM_CPU-1:0] CPU_CLOCK_TRUE,
   output logic [ccs_pkg::NUM_CPU-1:0] CPU_CLOCK_TRUE_OE,
   output logic [ccs_pkg::NUM_CPU-1:0] CPU_CLOCK_COMPLEMENT,
   output logic [ccs_pkg::NUM_CPU-1:0] CPU_CLOCK_COMPLEMENT_OE,
   output logic CPU_DRIVE_2X,
   // Gated single-ended outputs
   output logic [ccs_pkg::NUM_MID-1:0] MID_SPEED_CLOCK,
   output logic [ccs_pkg::NUM_PCI-1:0] PCI_CLK,
   output logic [ccs_pkg::NUM_PCIF-1:0] PCI_FREE_CLK,
   output logic REF_CLK,
   output logic USB_CLK,
   output logic DOT_CLK
);
   import ccs_pkg::*;

   function automatic logic rose(input logic now, input logic was);
      return now & ~was;
   endfunction

   function automatic logic fell(input logic now, input logic was);
      return ~now & was;
   endfunction

   // Two-stage synchronisers, third stage only for edge finding
   logic [NUM_SY-1:0] sy1;
   logic [NUM_SY-1:0] sy2;
   logic [NUM_SY-1:0] sy3;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         sy1 <= '0;
         sy2 <= '0;
         sy3 <= '0;
      end else begin
         sy1 <= {SDATA_IN, SCLK_IN, POWER_DOWN_N, PCI_HALT_N, CPU_HALT_N,
            VIDEO_HUB_CLOCK_RAW, USB_CLK_RAW, REF_CLK_RAW, PCI_CLK_RAW,
            MID_CLK_RAW, CPU_CLK_RAW};
         sy2 <= sy1;
         sy3 <= sy2;
      end
   end

   logic cpu_rise;
   logic pci_rise;
   logic scl_rise;
   logic scl_fall;
   logic i2_start;
   logic i2_stop;

   // Edge events found on the synchronised copies only
   always_comb begin
      cpu_rise = rose(sy2[SY_CPU], sy3[SY_CPU]);
      pci_rise = rose(sy2[SY_PCI], sy3[SY_PCI]);
      scl_rise = rose(sy2[SY_SCL], sy3[SY_SCL]);
      scl_fall = fell(sy2[SY_SCL], sy3[SY_SCL]);
      i2_start = sy2[SY_SCL] & sy3[SY_SCL] & fell(sy2[SY_SDA], sy3[SY_SDA]);
      i2_stop = sy2[SY_SCL] & sy3[SY_SCL] & rose(sy2[SY_SDA], sy3[SY_SDA]);
   end

   // Serial control slave
   ccs_i2c_e i2_state;
   ccs_i2c_e next_i2_state;
   logic [7:0] shift;
   logic [7:0] next_shift;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [3:0] pos;
   logic [3:0] next_pos;
   logic rd;
   logic next_rd;
   logic sda_oe;
   logic next_sda_oe;
   logic [NUM_RW_BYTES-1:0][7:0] ctl;
   logic [NUM_RW_BYTES-1:0][7:0] next_ctl;
   logic [7:0] tx_byte;

   // Read-back order: byte count first, then bytes 0 to 6
   always_comb begin
      tx_byte = 8'h00;
      if (pos == 4'h0) begin
         tx_byte = BYTE_COUNT_VAL;
      end else if (pos <= 4'(NUM_RW_BYTES)) begin
         tx_byte = ctl[pos - 4'h1];
      end else if (pos == 4'(BYTE_6 + 1)) begin
         tx_byte = {REVISION_ID, VENDOR_ID};
      end
   end

   always_comb begin
      next_i2_state = i2_state;
      next_shift = shift;
      next_bit_cnt = bit_cnt;
      next_pos = pos;
      next_rd = rd;
      next_sda_oe = sda_oe;
      next_ctl = ctl;
      if (i2_start) begin
         next_i2_state = I2_ADDR;
         next_bit_cnt = 4'h0;
         next_sda_oe = 1'b0;
      end else if (i2_stop) begin
         next_i2_state = I2_IDLE;
         next_sda_oe = 1'b0;
      end else begin
         case (i2_state)
            I2_ADDR, I2_WRX: begin
               if (scl_rise) begin
                  next_shift = {shift[6:0], sy2[SY_SDA]};
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  next_bit_cnt = 4'h0;
                  if (i2_state == I2_ADDR) begin
                     if (shift[7:1] == SLAVE_ADDR7) begin
                        next_rd = shift[0];
                        next_sda_oe = 1'b1;
                        next_i2_state = I2_AACK;
                     end else begin
                        next_i2_state = I2_IDLE;
                     end
                  end else begin
                     // Command code and byte count are dropped; byte 6
                     // and anything past it is ignored
                     if (pos >= 4'h2 && pos < 4'(NUM_RW_BYTES + 2)) begin
                        next_ctl[pos - 4'h2] = shift;
                     end
                     if (pos != 4'hF) begin
                        next_pos = pos + 4'h1;
                     end
                     next_sda_oe = 1'b1;
                     next_i2_state = I2_WACK;
                  end
               end
            end
            I2_AACK: begin
               if (scl_fall) begin
                  next_pos = 4'h0;
                  next_sda_oe = 1'b0;
                  next_i2_state = rd ? I2_RLOAD : I2_WRX;
               end
            end
            I2_WACK: begin
               if (scl_fall) begin
                  next_sda_oe = 1'b0;
                  next_i2_state = I2_WRX;
               end
            end
            I2_TX: begin
               if (scl_fall) begin
                  if (bit_cnt == 4'h8) begin
                     next_sda_oe = 1'b0;
                     next_i2_state = I2_RACK;
                  end else begin
                     next_sda_oe = ~shift[7];
                     next_shift = {shift[6:0], 1'b0};
                     next_bit_cnt = bit_cnt + 4'h1;
                  end
               end
            end
            I2_RACK: begin
               if (scl_rise) begin
                  next_i2_state = sy2[SY_SDA] ? I2_IDLE : I2_RLOAD;
               end
            end
            I2_RLOAD: begin
               // First data bit goes out right after the acknowledge bit
               // or, for the very first byte, the address acknowledge
               if (scl_fall || (pos == 4'h0 && !sy2[SY_SCL])) begin
                  next_sda_oe = ~tx_byte[7];
                  next_shift = {tx_byte[6:0], 1'b0};
                  next_bit_cnt = 4'h1;
                  if (pos != 4'hF) begin
                     next_pos = pos + 4'h1;
                  end
                  next_i2_state = I2_TX;
               end
            end
            I2_IDLE: begin
               next_sda_oe = 1'b0;
            end
            default: begin
               next_i2_state = I2_IDLE;
               next_sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         i2_state <= I2_IDLE;
         shift <= 8'h00;
         bit_cnt <= 4'h0;
         pos <= 4'h0;
         rd <= 1'b0;
         sda_oe <= 1'b0;
         ctl <= {RST_BYTE_5, RST_BYTE_4, RST_BYTE_3, RST_BYTE_2, RST_BYTE_1,
            RST_BYTE_0};
      end else begin
         i2_state <= next_i2_state;
         shift <= next_shift;
         bit_cnt <= next_bit_cnt;
         pos <= next_pos;
         rd <= next_rd;
         sda_oe <= next_sda_oe;
         ctl <= next_ctl;
      end
   end

   // Power management sampling; halts are taken on the owning clock edge
   ccs_pd_e pd_state;
   ccs_pd_e next_pd_state;
   logic [1:0] pd_low_cnt;
   logic [1:0] next_pd_low_cnt;
   logic [PD_SETTLE_W-1:0] settle;
   logic [PD_SETTLE_W-1:0] next_settle;
   logic cpu_halt;
   logic next_cpu_halt;
   logic pci_halt;
   logic next_pci_halt;

   always_comb begin
      next_pd_state = pd_state;
      next_pd_low_cnt = pd_low_cnt;
      next_settle = settle;
      next_cpu_halt = cpu_rise ? ~sy2[SY_CPU_HALT] : cpu_halt;
      next_pci_halt = pci_rise ? ~sy2[SY_PCI_HALT] : pci_halt;
      case (pd_state)
         PD_RUN: begin
            if (cpu_rise) begin
               if (!sy2[SY_PD]) begin
                  next_pd_low_cnt = pd_low_cnt + 2'h1;
                  if (pd_low_cnt == 2'h1) begin
                     next_pd_state = PD_DOWN;
                  end
               end else begin
                  next_pd_low_cnt = 2'h0;
               end
            end
         end
         PD_DOWN: begin
            // Release is seen on our own clock: the CPU clock may be dead
            next_pd_low_cnt = 2'h0;
            next_settle = '0;
            if (sy2[SY_PD]) begin
               next_pd_state = PD_SETTLE;
            end
         end
         PD_SETTLE: begin
            if (!sy2[SY_PD]) begin
               next_pd_state = PD_DOWN;
            end else if (settle == PD_SETTLE_W'(PD_SETTLE_CYCLES - 1)) begin
               next_pd_state = PD_RUN;
            end else begin
               next_settle = settle + PD_SETTLE_W'(1);
            end
         end
         default: begin
            next_pd_state = PD_RUN;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pd_state <= PD_RUN;
         pd_low_cnt <= 2'h0;
         settle <= '0;
         cpu_halt <= 1'b0;
         pci_halt <= 1'b0;
      end else begin
         pd_state <= next_pd_state;
         pd_low_cnt <= next_pd_low_cnt;
         settle <= next_settle;
         cpu_halt <= next_cpu_halt;
         pci_halt <= next_pci_halt;
      end
   end

   // Gate array: one glitch-free stopper per output
   logic pd_hold;
   logic [NUM_GATES-1:0] g_src;
   logic [NUM_GATES-1:0] g_run;
   logic [NUM_GATES-1:0] g_hold;
   logic [NUM_GATES-1:0] g_out;
   logic [NUM_GATES-1:0] g_stopped;

   always_comb begin
      pd_hold = (pd_state != PD_RUN);
      g_hold = '0;
      for (int i = 0; i < NUM_CPU; i++) begin
         g_src[G_CPU + i] = sy2[SY_CPU];
         g_hold[G_CPU + i] = ~ctl[BYTE_1][B1_STOP_UNDRIVEN];
         g_run[G_CPU + i] = ~(cpu_halt
            & ~ctl[BYTE_1][B1_FREERUN_LSB + i]);
      end
      for (int i = 0; i < NUM_MID; i++) begin
         // One shared source keeps the group in phase; video select moves SHARED_MID off it
         g_src[G_MID + i] = sy2[SY_MID];
         g_run[G_MID + i] = ctl[BYTE_4][i] & ~pd_hold;
      end
      if (ctl[BYTE_0][B0_VIDEO_SEL]) begin
         g_src[G_MID + SHARED_MID] = sy2[SY_VID];
      end
      for (int i = 0; i < NUM_PCI; i++) begin
         g_src[G_PCI + i] = sy2[SY_PCI];
         g_run[G_PCI + i] = ctl[BYTE_2][i] & ~pci_halt & ~pd_hold;
      end
      for (int i = 0; i < NUM_PCIF; i++) begin
         g_src[G_PCIF + i] = sy2[SY_PCI];
         g_run[G_PCIF + i] = ctl[BYTE_3][i] & ~pd_hold
            & ~(pci_halt & ctl[BYTE_3][B3_PCIF_STOP_LSB + i]);
      end
      // Reference stops at its own falling edge, possibly cycles later
      g_src[G_REF] = sy2[SY_REF];
      g_run[G_REF] = ~pd_hold;
      g_src[G_USB] = sy2[SY_USB];
      g_run[G_USB] = ctl[BYTE_3][B3_USB_EN] & ~pd_hold;
      g_src[G_DOT] = sy2[SY_USB];
      g_run[G_DOT] = ctl[BYTE_3][B3_DOT_EN] & ~pd_hold;
   end

   ccs_gate_if gif [NUM_GATES] ();

   for (genvar i = 0; i < NUM_GATES; i++) begin : g_gate
      assign gif[i].src = g_src[i];
      assign gif[i].run = g_run[i];
      assign gif[i].hold_level = g_hold[i];
      assign g_out[i] = gif[i].out;
      assign g_stopped[i] = gif[i].stopped;
      ccs_gate u_gate (
         .clk(CLK),
         .rst(SYS_RST),
         .port(gif[i])
      );
   end

   // CPU pair drive: power-down overrides halt; settle drives true high
   logic [NUM_CPU-1:0] cpu_t;
   logic [NUM_CPU-1:0] cpu_t_oe;
   logic [NUM_CPU-1:0] cpu_c;
   logic [NUM_CPU-1:0] cpu_c_oe;
   logic drive_2x;
   logic [NUM_CPU-1:0] next_cpu_t;
   logic [NUM_CPU-1:0] next_cpu_t_oe;
   logic [NUM_CPU-1:0] next_cpu_c;
   logic [NUM_CPU-1:0] next_cpu_c_oe;
   logic next_drive_2x;

   always_comb begin
      next_drive_2x = (pd_state == PD_DOWN)
         & ~ctl[BYTE_0][B0_PD_UNDRIVEN];
      for (int i = 0; i < NUM_CPU; i++) begin
         next_cpu_c[i] = 1'b0;
         next_cpu_c_oe[i] = 1'b0;
         next_cpu_t[i] = 1'b1;
         if (pd_state == PD_DOWN) begin
            next_cpu_t_oe[i] = ~ctl[BYTE_0][B0_PD_UNDRIVEN];
         end else if (pd_state == PD_SETTLE) begin
            next_cpu_t_oe[i] = 1'b1;
         end else if (g_stopped[G_CPU + i]) begin
            // Undriven while halted when B1_STOP_UNDRIVEN is set, else driven high; driven high once released
            next_cpu_t_oe[i] = ~ctl[BYTE_1][B1_STOP_UNDRIVEN]
               | ~cpu_halt;
         end else begin
            next_cpu_t[i] = g_out[G_CPU + i];
            next_cpu_t_oe[i] = 1'b1;
            next_cpu_c[i] = ~g_out[G_CPU + i];
            next_cpu_c_oe[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cpu_t <= '0;
         cpu_t_oe <= '0;
         cpu_c <= '0;
         cpu_c_oe <= '0;
         drive_2x <= 1'b0;
      end else begin
         cpu_t <= next_cpu_t;
         cpu_t_oe <= next_cpu_t_oe;
         cpu_c <= next_cpu_c;
         cpu_c_oe <= next_cpu_c_oe;
         drive_2x <= next_drive_2x;
      end
   end

   // Output mapping; the data pin only ever pulls low
   assign SDATA_OUT = 1'b0;
   assign SDATA_OE = sda_oe;
   assign CPU_CLOCK_TRUE = cpu_t;
   assign CPU_CLOCK_TRUE_OE = cpu_t_oe;
   assign CPU_CLOCK_COMPLEMENT = cpu_c;
   assign CPU_CLOCK_COMPLEMENT_OE = cpu_c_oe;
   assign CPU_DRIVE_2X = drive_2x;
   assign MID_SPEED_CLOCK = g_out[G_MID +: NUM_MID];
   assign PCI_CLK = g_out[G_PCI +: NUM_PCI];
   assign PCI_FREE_CLK = g_out[G_PCIF +: NUM_PCIF];
   assign REF_CLK = g_out[G_REF];
   assign USB_CLK = g_out[G_USB];
   assign DOT_CLK = g_out[G_DOT];
endmodule

/* design/ccs_pkg.sv */
package ccs_pkg;
   // Control byte numbering on the serial link
   localparam int BYTE_0 = 0;
   localparam int BYTE_1 = 1;
   localparam int BYTE_2 = 2;
   localparam int BYTE_3 = 3;
   localparam int BYTE_4 = 4;
   localparam int BYTE_5 = 5;
   localparam int BYTE_6 = 6;
   localparam int NUM_RW_BYTES = 6;
   localparam logic [7:0] BYTE_COUNT_VAL = 8'h07;
   // Reset values of the writable bytes
   localparam logic [7:0] RST_BYTE_0 = 8'h08;
   localparam logic [7:0] RST_BYTE_1 = 8'h07;
   localparam logic [7:0] RST_BYTE_2 = 8'h7F;
   localparam logic [7:0] RST_BYTE_3 = 8'hC7;
   localparam logic [7:0] RST_BYTE_4 = 8'h3F;
   localparam logic [7:0] RST_BYTE_5 = 8'h00;
   // Field positions used by the gating logic
   localparam int B0_PD_UNDRIVEN = 6;
   localparam int B0_VIDEO_SEL = 5;
   localparam int B1_STOP_UNDRIVEN = 6;
   localparam int B1_FREERUN_LSB = 3;
   localparam int B3_PCIF_STOP_LSB = 3;
   localparam int B3_USB_EN = 6;
   localparam int B3_DOT_EN = 7;
   // Serial slave address, seven bits
   localparam logic [6:0] SLAVE_ADDR7 = 7'h69;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int PD_SETTLE_NS = 1800000;
   localparam int PD_SETTLE_CYC = PD_SETTLE_NS / CLK_PERIOD_NS;
   localparam int PD_SETTLE_W = 17;
   // Output groups inside the gate array
   localparam int NUM_CPU = 3;
   localparam int NUM_MID = 6;
   localparam int NUM_PCI = 7;
   localparam int NUM_PCIF = 3;
   localparam int SHARED_MID = 4;
   localparam int G_CPU = 0;
   localparam int G_MID = G_CPU + NUM_CPU;
   localparam int G_PCI = G_MID + NUM_MID;
   localparam int G_PCIF = G_PCI + NUM_PCI;
   localparam int G_REF = G_PCIF + NUM_PCIF;
   localparam int G_USB = G_REF + 1;
   localparam int G_DOT = G_USB + 1;
   localparam int NUM_GATES = G_DOT + 1;
   // Bit positions in the synchronised pin vector
   localparam int SY_CPU = 0;
   localparam int SY_MID = 1;
   localparam int SY_PCI = 2;
   localparam int SY_REF = 3;
   localparam int SY_USB = 4;
   localparam int SY_VID = 5;
   localparam int SY_CPU_HALT = 6;
   localparam int SY_PCI_HALT = 7;
   localparam int SY_PD = 8;
   localparam int SY_SCL = 9;
   localparam int SY_SDA = 10;
   localparam int NUM_SY = 11;

   typedef enum logic [7:0] {
      I2_IDLE = 8'h01,
      I2_ADDR = 8'h02,
      I2_AACK = 8'h04,
      I2_WRX = 8'h08,
      I2_WACK = 8'h10,
      I2_TX = 8'h20,
      I2_RACK = 8'h40,
      I2_RLOAD = 8'h80
   } ccs_i2c_e;

   typedef enum logic [2:0] {
      PD_RUN = 3'h1,
      PD_DOWN = 3'h2,
      PD_SETTLE = 3'h4
   } ccs_pd_e;
endpackage

/* design/ccs_gate_if.sv */
`timescale 1ns/1ps
interface ccs_gate_if;
   logic src;
   logic run;
   logic hold_level;
   logic out;
   logic stopped;
   modport gate (input src, input run, input hold_level,
      output out, output stopped);
   modport ctrl (output src, output run, output hold_level,
      input out, input stopped);
endinterface

/* design/ccs_gate.sv */
`timescale 1ns/1ps
module ccs_gate (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Gated clock channel
   ccs_gate_if.gate port
);
   import ccs_pkg::*;

   logic stopped;
   logic out;
   logic next_stopped;
   logic next_out;

   // Freeze or release only while the source sits at the hold level,
   // so the output never shows a runt pulse
   always_comb begin
      next_stopped = stopped;
      if (!stopped && !port.run && port.src == port.hold_level) begin
         next_stopped = 1'b1;
      end else if (stopped && port.run && port.src == port.hold_level) begin
         next_stopped = 1'b0;
      end
      next_out = next_stopped ? port.hold_level : port.src;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stopped <= 1'b0;
         out <= 1'b0;
      end else begin
         stopped <= next_stopped;
         out <= next_out;
      end
   end

   assign port.out = out;
   assign port.stopped = stopped;
endmodule

/* tb/ccs_clock_stop_props.sv */
`timescale 1ns/1ps
module ccs_clock_stop_props #(
   parameter int PD_SETTLE_CYCLES = 20
) (
   // Clock, reset and control pins
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CPU_HALT_N,
   input wire logic PCI_HALT_N,
   input wire logic POWER_DOWN_N,
   // Watched outputs
   input wire logic [2:0] CPU_CLOCK_TRUE,
   input wire logic [2:0] CPU_CLOCK_TRUE_OE,
   input wire logic [2:0] CPU_CLOCK_COMPLEMENT_OE,
   input wire logic CPU_DRIVE_2X,
   input wire logic [5:0] MID_SPEED_CLOCK,
   input wire logic [6:0] PCI_CLK,
   input wire logic REF_CLK
);
   // Long enough for two syncs, two raw periods and the gate flop
   localparam logic [5:0] LONG = 6'h28;
   logic [5:0] halt_cnt, pci_cnt, pd_cnt;
   logic [5:0] next_halt_cnt, next_pci_cnt, next_pd_cnt;
   int wait_cnt, next_wait_cnt;
   function automatic logic [5:0] sat(input logic low, input logic [5:0] c);
      return !low ? 6'h00 : (c == 6'h3F) ? c : c + 6'h01;
   endfunction
   // Low-time counters saturate; the wait counts until all pairs run
   always_comb begin
      next_halt_cnt = sat(!CPU_HALT_N, halt_cnt);
      next_pci_cnt = sat(!PCI_HALT_N, pci_cnt);
      next_pd_cnt = sat(!POWER_DOWN_N, pd_cnt);
      next_wait_cnt = (POWER_DOWN_N && CPU_HALT_N &&
         CPU_CLOCK_COMPLEMENT_OE != 3'h7) ? wait_cnt + 1 : 0;
   end
   // Helper registers
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         halt_cnt <= 6'h00;
         pci_cnt <= 6'h00;
         pd_cnt <= 6'h00;
         wait_cnt <= 0;
      end else begin
         halt_cnt <= next_halt_cnt;
         pci_cnt <= next_pci_cnt;
         pd_cnt <= next_pd_cnt;
         wait_cnt <= next_wait_cnt;
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   sequence halt_release;
      $rose(CPU_HALT_N) && POWER_DOWN_N;
   endsequence
   sequence pairs_running;
      CPU_CLOCK_COMPLEMENT_OE == 3'h7;
   endsequence
   reset_quiet_a: assert property ($past(SYS_RST) |->
      (CPU_CLOCK_TRUE_OE | CPU_CLOCK_COMPLEMENT_OE) == 3'h0)
      else $error("CPU drive active after reset");
   mid_phase_a: assert property (
      (MID_SPEED_CLOCK & ~$past(MID_SPEED_CLOCK) & 6'h2F) != 6'h00 |->
      (~MID_SPEED_CLOCK & $past(MID_SPEED_CLOCK) & 6'h2F) == 6'h00)
      else $error("mid-speed outputs out of phase");
   halt_frozen_a: assert property (halt_cnt >= LONG |->
      ((CPU_CLOCK_TRUE ^ $past(CPU_CLOCK_TRUE)) &
      ~CPU_CLOCK_COMPLEMENT_OE) == 3'h0)
      else $error("stopped CPU pair still toggles");
   halt_resume_a: assert property (
      halt_release |-> ##[1:60] pairs_running)
      else $error("CPU pairs late after halt release");
   pd_hold_a: assert property (pd_cnt >= LONG |->
      MID_SPEED_CLOCK == 6'h00 && PCI_CLK == 7'h00 && !REF_CLK)
      else $error("clock running in power-down");
   pd_cpu_a: assert property (pd_cnt >= LONG |->
      CPU_CLOCK_COMPLEMENT_OE == 3'h0 &&
      CPU_CLOCK_TRUE_OE == {3{CPU_DRIVE_2X}})
      else $error("CPU drive wrong in power-down");
   pci_stop_a: assert property (pci_cnt >= LONG |->
      PCI_CLK == 7'h00)
      else $error("PCI clock running while halted");
   cpu_restart_a: assert property (
      wait_cnt <= PD_SETTLE_CYCLES + 60)
      else $error("CPU pairs not running in time");
endmodule

bind ccs_clock_stop ccs_clock_stop_props #(
   .PD_SETTLE_CYCLES(PD_SETTLE_CYCLES)
) ccs_clock_stop_props_i (
   .CLK, .SYS_RST, .CPU_HALT_N, .PCI_HALT_N, .POWER_DOWN_N,
   .CPU_CLOCK_TRUE, .CPU_CLOCK_TRUE_OE, .CPU_CLOCK_COMPLEMENT_OE,
   .CPU_DRIVE_2X, .MID_SPEED_CLOCK, .PCI_CLK, .REF_CLK
);

/* tb/ccs_i2c_host.sv */
`timescale 1ns/1ps
module ccs_i2c_host (
   // Bench clock and shared data wire
   input wire logic clk,
   input wire logic sda_wire,
   // Clock level and data pull-down
   output logic scl = 1'b1,
   output logic sda_low = 1'b0
);
   // Eight CLK per phase; three phases make a 24 CLK, 600 ns bit, far above 100 kHz
   localparam int HALF = 8;
   logic [7:0] got [0:7];
   task automatic tick();
      repeat (HALF) @(posedge clk);
   endtask
   // Data moves only while the clock is low
   task automatic put_bit(input logic b, output logic seen);
      sda_low <= !b;
      tick();
      scl <= 1'b1;
      tick();
      seen = sda_wire;
      scl <= 1'b0;
      tick();
   endtask
   task automatic start();
      sda_low <= 1'b1;
      tick();
      scl <= 1'b0;
      tick();
   endtask
   task automatic stop();
      sda_low <= 1'b1;
      tick();
      scl <= 1'b1;
      tick();
      sda_low <= 1'b0;
      tick();
   endtask
   task automatic xfer(input logic [7:0] tx, input logic last,
      output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         put_bit(tx[i], rx[i]);
      end
      put_bit(last, ack);
   endtask
   // Dummy code and count first, then bytes upward from byte 0
   task automatic blk_write(input logic [7:0] b [0:6], input int n);
      logic [7:0] rx;
      logic a;
      start();
      xfer(8'hD2, 1'b1, rx, a);
      xfer(8'h00, 1'b1, rx, a);
      xfer(8'(n), 1'b1, rx, a);
      for (int i = 0; i < n; i++) begin
         xfer(b[i], 1'b1, rx, a);
      end
      stop();
   endtask
   // Count then bytes 0 to 6; the last one is refused to end the read
   task automatic blk_read();
      logic a;
      start();
      xfer(8'hD3, 1'b1, got[0], a);
      for (int i = 0; i < 8; i++) begin
         xfer(8'hFF, i == 7, got[i], a);
      end
      stop();
   endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import ccs_pkg::*;
   localparam logic [3:0] REV = 4'hA; // Arbitrary value
   localparam logic [3:0] VEN = 4'h6; // Arbitrary value
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic slow = 1'b0;
   logic [1:0] div = 2'h0;
   logic cpu_halt_n = 1'b1;
   logic pci_halt_n = 1'b1, power_down_n = 1'b1, sda_out;
   logic scl, sda_low, sda_oe, sda_wire, drive_2x, ref_clk, usb, dot, nc_hi;
   logic [2:0] t, c, t_oe, c_oe, pcif, pcif_hi, t_lo, c_bad, aux_hi;
   logic [5:0] mid, mid_hi;
   logic [6:0] pci, pci_hi;
   logic [7:0] regs [0:6] = '{RST_BYTE_0, RST_BYTE_1, RST_BYTE_2,
      RST_BYTE_3, RST_BYTE_4, RST_BYTE_5, 8'h00};
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;
   // Pull-up: the wire is low while either side pulls it
   assign sda_wire = !(sda_low || (sda_oe && !sda_out));
   initial forever #12.5 clk = ~clk;
   // Raw clocks at 200 ns, plus a watchdog on the whole run
   always @(posedge clk) begin
      div <= div + 2'h1;
      slow <= (div == 2'h3) ? !slow : slow;
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   ccs_clock_stop #(.PD_SETTLE_CYCLES(20), .REVISION_ID(REV),
      .VENDOR_ID(VEN)) ccs_clock_stop_i (
      .CLK(clk), .SYS_RST(sys_rst), .CPU_CLK_RAW(slow), .MID_CLK_RAW(slow),
      .PCI_CLK_RAW(slow), .REF_CLK_RAW(slow), .USB_CLK_RAW(slow),
      .VIDEO_HUB_CLOCK_RAW(!slow), .CPU_HALT_N(cpu_halt_n),
      .PCI_HALT_N(pci_halt_n), .POWER_DOWN_N(power_down_n),
      .SCLK_IN(scl), .SDATA_IN(sda_wire), .SDATA_OUT(sda_out),
      .SDATA_OE(sda_oe), .CPU_CLOCK_TRUE(t), .CPU_CLOCK_TRUE_OE(t_oe),
      .CPU_CLOCK_COMPLEMENT(c), .CPU_CLOCK_COMPLEMENT_OE(c_oe),
      .CPU_DRIVE_2X(drive_2x), .MID_SPEED_CLOCK(mid), .PCI_CLK(pci),
      .PCI_FREE_CLK(pcif), .REF_CLK(ref_clk), .USB_CLK(usb), .DOT_CLK(dot));
   ccs_i2c_host h (.clk, .sda_wire, .scl, .sda_low);
   task automatic check(input string what, input logic [7:0] exp,
      input logic [7:0] seen);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Two raw periods of activity, gathered per output group
   task automatic watch();
      {mid_hi, pci_hi, pcif_hi, t_lo, nc_hi, c_bad, aux_hi} = '0;
      repeat (16) begin
         @(posedge clk);
         mid_hi |= mid;
         pci_hi |= pci;
         pcif_hi |= pcif;
         t_lo |= ~t;
         nc_hi |= |{mid, pci, pcif, ref_clk, usb, dot};
         c_bad |= (t ~^ c) & c_oe;
         aux_hi |= {ref_clk, usb, dot};
      end
   endtask
   task automatic drive_wait();
      for (int i = 0; i < 14 && t_oe !== 3'h7; i++) begin
         @(posedge clk);
      end
      check("drive high", 8'h07, {5'h0, t_oe});
   endtask
   task automatic t_regs();
      h.blk_read();
      check("byte1", RST_BYTE_1, h.got[2]);
      check("byte3", RST_BYTE_3, h.got[4]);
      check("byte4", RST_BYTE_4, h.got[5]);
      check("byte5", RST_BYTE_5, h.got[6]);
      regs[4] = 8'hC5;
      regs[5] = 8'hA5;
      h.blk_write(regs, 7);
      h.blk_read();
      check("byte4 wr", 8'hC5, h.got[5]);
      check("byte5 wr", 8'hA5, h.got[6]);
      check("byte6", {REV, VEN}, h.got[7]);
      watch();
      check("mid off", 8'h05, {2'h0, mid_hi});
      regs[4] = RST_BYTE_4;
      h.blk_write(regs, 5);
      watch();
      check("mid on", 8'h3F, {2'h0, mid_hi});
      regs[0] = 8'h28;
      h.blk_write(regs, 1);
      check("video", 8'h01, {7'h0, mid[4] ^ mid[0]});
   endtask
   task automatic t_halt();
      regs[1] = 8'h17;
      h.blk_write(regs, 2);
      cpu_halt_n <= 1'b0;
      cyc(40);
      watch();
      check("halt comp", 8'h02, {5'h0, c_oe});
      check("halt true", 8'h07, {5'h0, t_oe});
      check("halt low", 8'h02, {5'h0, t_lo});
      check("comp inv", 8'h00, {5'h0, c_bad});
      cpu_halt_n <= 1'b1;
      cyc(60);
      check("resume", 8'h07, {5'h0, c_oe});
      regs[1] = 8'h47;
      h.blk_write(regs, 2);
      cpu_halt_n <= 1'b0;
      cyc(40);
      check("halt float", 8'h00, {2'h0, t_oe, c_oe});
      cpu_halt_n <= 1'b1;
      drive_wait();
      regs[1] = RST_BYTE_1;
      h.blk_write(regs, 2);
   endtask
   task automatic t_pd(input logic [7:0] b0, input logic [2:0] e);
      regs[0] = b0;
      h.blk_write(regs, 1);
      power_down_n <= 1'b0;
      cyc(40);
      watch();
      check("pd quiet", 8'h00, {7'h0, nc_hi});
      check("pd true", {5'h0, e}, {5'h0, t_oe});
      check("pd 2x", {7'h0, e[0]}, {7'h0, drive_2x});
      check("pd comp", 8'h00, {5'h0, c_oe});
      power_down_n <= 1'b1;
      drive_wait();
      cyc(80);
      watch();
      check("pd exit", 8'h3F, {2'h0, mid_hi});
   endtask
   task automatic t_pci();
      regs[3] = 8'hEF;
      h.blk_write(regs, 4);
      @(posedge clk iff div == 2'h1);
      pci_halt_n <= 1'b0;
      cyc(40);
      watch();
      check("pci stop", 8'h00, {1'b0, pci_hi});
      check("pcif stop", 8'h02, {5'h0, pcif_hi});
      pci_halt_n <= 1'b1;
      cyc(40);
      watch();
      check("pci run", 8'h7F, {1'b0, pci_hi});
      check("aux run", 8'h07, {5'h0, aux_hi});
   endtask
   task automatic report_and_stop();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      cyc(4);
      t_regs();
      t_halt();
      t_pd(8'h08, 3'h7);
      t_pd(8'h48, 3'h0);
      t_pci();
      report_and_stop();
   end
endmodule
